// ---- acquisition_event_monitor.sv ----
`timescale 1ns/1ps
// Behaviour
// RULE_01 - captured trigger raises used event
// RULE_02 - too-fast trigger raises ignored event
// RULE_03 - active acquisition flags frame start, end
// RULE_04 - frame-valid event on any frame start
// RULE_05 - lock and unlock events
// RULE_06 - overflow event on lost bandwidth
// RULE_07 - frame lost when memory is full
// RULE_08 - early line trigger held until line ends
// RULE_09 - too-fast line trigger, once per frame
// RULE_10 - slow encoder for multiplier raises event
// RULE_11 - reverse counter overflow raises event
// RULE_12 - camera missed trigger event
// RULE_13 - camera overrun event
// RULE_14 - link error event with source code
// RULE_15 - lane bitmask, bit 0 is lane one
// RULE_16 - 32-bit error count per lane
// RULE_17 - transfer start-of-frame on first pixel
// RULE_18 - transfer end-of-frame on last pixel
// RULE_19 - end-of-line and end-of-N-lines events
// RULE_20 - fixed count stops itself, else host stop
// RULE_21 - short trigger pulses rejected
// RULE_22 - images queued in order, overflow discarded
// RULE_23 - sticky flags, write-one clear, enable mask
module acquisition_event_monitor
	import event_monitor_pkg::*;
(
	input  wire logic                  mclk_in,
	input  wire logic                  nrst_in,
	// external trigger and configuration
	input  wire logic                  ext_trig_in,
	input  wire logic [CNT16_W-1:0]    debounce_cycles_in,
	input  wire logic                  acq_active_in,
	input  wire logic                  cam_ready_in,
	// camera frame / line framing
	input  wire logic                  cam_fval_in,
	input  wire logic                  cam_lval_in,
	// line trigger path
	input  wire logic                  line_trig_in,
	output logic                       line_trig_out,
	// encoder
	input  wire logic                  enc_pulse_in,
	input  wire logic                  enc_reverse_in,
	input  wire logic [CNT16_W-1:0]    enc_min_period_in,
	input  wire logic [CNT16_W-1:0]    enc_rev_limit_in,
	// camera status reports (one-cycle pulses)
	input  wire logic                  cam_missed_in,
	input  wire logic                  cam_overrun_in,
	// link lanes
	input  wire logic [LANES-1:0]      lane_lock_in,
	input  wire logic [LANES-1:0]      lane_req_in,
	input  wire lane_err_type          lane_err_in,
	output logic [2:0]                 err_src_out,
	output logic [LANES-1:0]           err_lanes_out,
	output logic [LANES*LANE_CNT_W-1:0] lane_cnt_out,
	// acquired pixel stream into on-board memory
	input  wire logic                  pix_valid_in,
	input  wire pix_beat_type          pix_in,
	input  wire logic                  store_busy_in,
	// transfer to host
	input  wire logic                  xfer_start_in,
	input  wire logic                  xfer_stop_in,
	input  wire logic [CNT16_W-1:0]    xfer_frames_in,
	input  wire logic [CNT16_W-1:0]    nlines_in,
	input  wire logic                  host_ready_in,
	output logic                       host_valid_out,
	output pix_beat_type               host_data_out,
	output logic                       xfer_busy_out,
	// event status
	input  wire logic [NUM_EV-1:0]     ev_clear_in,
	input  wire logic [NUM_EV-1:0]     ev_enable_in,
	output logic [NUM_EV-1:0]          ev_status_out,
	output logic                       attention_out
);
	localparam int BW = $bits(pix_beat_type);

	function automatic logic rise(input logic cur, input logic prev);
		return cur && !prev;
	endfunction : rise

	function automatic logic [CNT16_W-1:0] sat_inc(
		input logic [CNT16_W-1:0] v);
		return (v == CNT16_MAX) ? v : v + CNT16_ONE;
	endfunction : sat_inc

	logic [NUM_EV-1:0] ev;

	// trigger debounce
	logic [CNT16_W-1:0] db_cnt_r, db_cnt_nxt;
	logic               trig_ok_r, trig_ok_nxt;
	logic               trig_valid;
	logic               fval_r, lval_r, lock_r, enc_r;
	logic               all_lock;
	logic               frame_busy_r, frame_busy_nxt;

	// pulse counted while high, taken once past the minimum
	always_comb begin
		db_cnt_nxt  = ext_trig_in ? sat_inc(db_cnt_r) : CNT16_ZERO;
		trig_ok_nxt = ext_trig_in && trig_ok_r;
		trig_valid  = 1'b0;
		if (ext_trig_in && !trig_ok_r &&
		    db_cnt_r >= debounce_cycles_in) begin // [RULE_21]
			trig_valid  = 1'b1;
			trig_ok_nxt = 1'b1;
		end
	end

	// frame in flight from used trigger to frame end
	always_comb begin
		frame_busy_nxt = frame_busy_r;
		if (!cam_fval_in && fval_r) begin
			frame_busy_nxt = 1'b0;
		end
		if (trig_valid && !frame_busy_r && cam_ready_in) begin
			frame_busy_nxt = 1'b1;
		end
	end

	assign all_lock = ((lane_lock_in & lane_req_in) == lane_req_in);

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			db_cnt_r     <= CNT16_ZERO;
			trig_ok_r    <= 1'b0;
			frame_busy_r <= 1'b0;
			fval_r       <= 1'b0;
			lval_r       <= 1'b0;
			lock_r       <= 1'b0;
			enc_r        <= 1'b0;
		end else begin
			db_cnt_r     <= db_cnt_nxt;
			trig_ok_r    <= trig_ok_nxt;
			frame_busy_r <= frame_busy_nxt;
			fval_r       <= cam_fval_in;
			lval_r       <= cam_lval_in;
			lock_r       <= all_lock;
			enc_r        <= enc_pulse_in;
		end
	end

	// line trigger hold-off
	logic line_busy_r, line_busy_nxt;
	logic line_pend_r, line_pend_nxt;
	logic fast_seen_r, fast_seen_nxt;
	logic lt_out_nxt, lt_out_r;
	logic lt_fast;

	always_comb begin
		line_busy_nxt = line_busy_r;
		line_pend_nxt = line_pend_r;
		fast_seen_nxt = fast_seen_r;
		lt_out_nxt    = 1'b0;
		lt_fast       = 1'b0;
		if (!cam_lval_in && lval_r) begin
			line_busy_nxt = 1'b0;
		end
		if (line_trig_in) begin
			if (line_busy_r || line_pend_r) begin
				line_pend_nxt = 1'b1; // [RULE_08]
				if (!fast_seen_r) begin
					lt_fast       = 1'b1; // [RULE_09]
					fast_seen_nxt = 1'b1;
				end
			end else begin
				lt_out_nxt    = 1'b1;
				line_busy_nxt = 1'b1;
			end
		end else if (line_pend_r && !line_busy_nxt) begin
			// held trigger goes out once the line is done
			lt_out_nxt    = 1'b1; // [RULE_08]
			line_pend_nxt = 1'b0;
			line_busy_nxt = 1'b1;
		end
		if (rise(cam_fval_in, fval_r)) begin
			fast_seen_nxt = 1'b0; // [RULE_09]
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			line_busy_r <= 1'b0;
			line_pend_r <= 1'b0;
			fast_seen_r <= 1'b0;
			lt_out_r    <= 1'b0;
		end else begin
			line_busy_r <= line_busy_nxt;
			line_pend_r <= line_pend_nxt;
			fast_seen_r <= fast_seen_nxt;
			lt_out_r    <= lt_out_nxt;
		end
	end
	assign line_trig_out = lt_out_r;

	// encoder monitors
	logic [CNT16_W-1:0] enc_per_r, enc_per_nxt;
	logic [CNT16_W-1:0] rev_cnt_r, rev_cnt_nxt;
	logic               enc_slow, rev_ovf;

	// a period longer than the multiplier can subdivide is too slow
	always_comb begin
		enc_per_nxt = sat_inc(enc_per_r);
		rev_cnt_nxt = rev_cnt_r;
		enc_slow    = 1'b0;
		rev_ovf     = 1'b0;
		if (rise(enc_pulse_in, enc_r)) begin
			enc_per_nxt = CNT16_ZERO;
			enc_slow    = (enc_per_r > enc_min_period_in); // [RULE_10]
			if (enc_reverse_in) begin
				if (rev_cnt_r >= enc_rev_limit_in) begin
					rev_ovf = 1'b1; // [RULE_11]
				end else begin
					rev_cnt_nxt = rev_cnt_r + CNT16_ONE;
				end
			end else if (rev_cnt_r != CNT16_ZERO) begin
				rev_cnt_nxt = rev_cnt_r - CNT16_ONE;
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			enc_per_r <= CNT16_ZERO;
			rev_cnt_r <= CNT16_ZERO;
		end else begin
			enc_per_r <= enc_per_nxt;
			rev_cnt_r <= rev_cnt_nxt;
		end
	end

	// link errors
	logic [LANE_CNT_W-1:0] lane_cnt_r [LANES];
	logic [LANE_CNT_W-1:0] lane_cnt_nxt [LANES];
	logic [2:0]            src_r, src_nxt;
	logic [LANES-1:0]      lmask_r, lmask_nxt;

	always_comb begin
		src_nxt   = src_r;
		lmask_nxt = lmask_r;
		for (int i = 0; i < LANES; i++) begin
			lane_cnt_nxt[i] = lane_cnt_r[i];
			if (lane_err_in.err && lane_err_in.lanes[i]) begin
				lane_cnt_nxt[i] = lane_cnt_r[i] + LANE_CNT_ONE; // [RULE_16]
			end
		end
		if (lane_err_in.err) begin
			src_nxt   = lane_err_in.src;   // [RULE_14]
			lmask_nxt = lane_err_in.lanes; // [RULE_15]
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			src_r   <= ERR_SRC_NONE;
			lmask_r <= '0;
			for (int i = 0; i < LANES; i++) begin
				lane_cnt_r[i] <= '0;
			end
		end else begin
			src_r   <= src_nxt;
			lmask_r <= lmask_nxt;
			for (int i = 0; i < LANES; i++) begin
				lane_cnt_r[i] <= lane_cnt_nxt[i];
			end
		end
	end

	assign err_src_out   = src_r;
	assign err_lanes_out = lmask_r;
	always_comb begin
		for (int i = 0; i < LANES; i++) begin
			lane_cnt_out[i*LANE_CNT_W +: LANE_CNT_W] = lane_cnt_r[i];
		end
	end

	// frame memory
	logic         fifo_in_ready, fifo_out_valid, fifo_rd_ready;
	pix_beat_type fifo_out;
	logic         drop_r, drop_nxt;
	logic         fifo_wr, frame_lost, data_ovf;

	// a frame that starts with no room is discarded whole; a frame
	// that runs out of room midway is an overflow
	always_comb begin
		drop_nxt   = drop_r;
		frame_lost = 1'b0;
		data_ovf   = 1'b0;
		fifo_wr    = 1'b0;
		if (pix_valid_in) begin
			if (pix_in.sof) begin
				drop_nxt = !fifo_in_ready;
				frame_lost = !fifo_in_ready; // [RULE_07] [RULE_22]
			end
			if (!(pix_in.sof ? !fifo_in_ready : drop_r)) begin
				fifo_wr  = fifo_in_ready;
				data_ovf = !fifo_in_ready || store_busy_in; // [RULE_06]
				if (!fifo_in_ready) begin
					drop_nxt = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			drop_r <= 1'b0;
		end else begin
			drop_r <= drop_nxt;
		end
	end

	event_fifo #(
		.WIDTH (BW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk_in       (mclk_in),
		.nrst_in       (nrst_in),
		.clr_in        (1'b0),
		.in_valid_in   (fifo_wr),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (pix_in),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (fifo_rd_ready),
		.out_data_out  (fifo_out)
	); // [RULE_22]

	// transfer engine
	xfer_state_type     xst_r, xst_nxt;
	logic [CNT16_W-1:0] fr_cnt_r, fr_cnt_nxt;
	logic [CNT16_W-1:0] ln_cnt_r, ln_cnt_nxt;
	logic               stop_req_r, stop_req_nxt;
	logic               x_sof, x_eof, x_eol, x_eonl, x_end, moving;

	assign moving        = (xst_r != XF_IDLE) && fifo_out_valid;
	assign fifo_rd_ready = (xst_r != XF_IDLE) && host_ready_in;
	assign host_valid_out = moving;
	assign host_data_out  = fifo_out;
	assign xfer_busy_out  = (xst_r != XF_IDLE);

	always_comb begin
		xst_nxt      = xst_r;
		fr_cnt_nxt   = fr_cnt_r;
		ln_cnt_nxt   = ln_cnt_r;
		stop_req_nxt = stop_req_r || xfer_stop_in;
		x_sof  = 1'b0;
		x_eof  = 1'b0;
		x_eol  = 1'b0;
		x_eonl = 1'b0;
		x_end  = 1'b0;
		if (moving && host_ready_in) begin
			x_sof = fifo_out.sof; // [RULE_17]
			x_eof = fifo_out.eof; // [RULE_18]
			x_eol = fifo_out.eol; // [RULE_19]
			if (fifo_out.eol) begin
				ln_cnt_nxt = ln_cnt_r + CNT16_ONE;
				if (ln_cnt_nxt == nlines_in) begin
					x_eonl     = 1'b1; // [RULE_19]
					ln_cnt_nxt = CNT16_ZERO;
				end
			end
			if (fifo_out.eof) begin
				fr_cnt_nxt = fr_cnt_r + CNT16_ONE;
			end
		end
		case (xst_r)
			XF_IDLE: begin
				stop_req_nxt = 1'b0;
				if (xfer_start_in) begin
					xst_nxt    = XF_RUN;
					fr_cnt_nxt = CNT16_ZERO;
					ln_cnt_nxt = CNT16_ZERO;
				end
			end
			XF_RUN: begin
				// zero frames means run until the host stops it
				if ((x_eof && xfer_frames_in != CNT16_ZERO &&
				     fr_cnt_nxt == xfer_frames_in) || stop_req_nxt) begin
					xst_nxt = XF_STOP; // [RULE_20]
				end
			end
			XF_STOP: begin
				// drain what is queued, then end once the memory is empty or the frame count is reached
				if (!fifo_out_valid || (x_eof && !stop_req_r) ||
				    (xfer_frames_in != CNT16_ZERO &&
				     fr_cnt_r == xfer_frames_in)) begin
					xst_nxt = XF_IDLE;
					x_end   = 1'b1; // [RULE_20]
				end
			end
			default: xst_nxt = XF_IDLE;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			xst_r      <= XF_IDLE;
			fr_cnt_r   <= CNT16_ZERO;
			ln_cnt_r   <= CNT16_ZERO;
			stop_req_r <= 1'b0;
		end else begin
			xst_r      <= xst_nxt;
			fr_cnt_r   <= fr_cnt_nxt;
			ln_cnt_r   <= ln_cnt_nxt;
			stop_req_r <= stop_req_nxt;
		end
	end

	// events
	logic [NUM_EV-1:0] status_r, status_nxt;
	logic              fv_rise;

	assign fv_rise = rise(cam_fval_in, fval_r);

	always_comb begin
		ev = '0;
		ev[EV_TRIG_USED]    = trig_valid && !frame_busy_r &&
		                      cam_ready_in; // [RULE_01]
		ev[EV_TRIG_IGNORED] = trig_valid &&
		                      (frame_busy_r || !cam_ready_in); // [RULE_02]
		ev[EV_ACQ_SOF]      = acq_active_in && fv_rise; // [RULE_03]
		ev[EV_ACQ_EOF]      = acq_active_in && !cam_fval_in &&
		                      fval_r; // [RULE_03]
		ev[EV_FRAME_VALID]  = fv_rise; // [RULE_04]
		ev[EV_LINK_LOCK]    = all_lock && !lock_r; // [RULE_05]
		ev[EV_LINK_UNLOCK]  = !all_lock && lock_r; // [RULE_05]
		ev[EV_DATA_OVF]     = data_ovf;
		ev[EV_FRAME_LOST]   = frame_lost;
		ev[EV_LTRIG_FAST]   = lt_fast;
		ev[EV_TRIG_SLOW]    = enc_slow;
		ev[EV_REV_OVF]      = rev_ovf;
		ev[EV_CAM_MISSED]   = cam_missed_in;  // [RULE_12]
		ev[EV_CAM_OVERRUN]  = cam_overrun_in; // [RULE_13]
		ev[EV_LINK_ERROR]   = lane_err_in.err; // [RULE_14]
		ev[EV_XFER_SOF]     = x_sof;
		ev[EV_XFER_EOF]     = x_eof;
		ev[EV_XFER_EOL]     = x_eol;
		ev[EV_XFER_EONL]    = x_eonl;
		ev[EV_XFER_END]     = x_end;
		// set wins over a clear in the same cycle
		status_nxt = (status_r & ~ev_clear_in) | ev; // [RULE_23]
	end

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			status_r <= '0;
		end else begin
			status_r <= status_nxt;
		end
	end

	assign ev_status_out = status_r;
	assign attention_out = |(status_r & ev_enable_in); // [RULE_23]
endmodule : acquisition_event_monitor

// ---- event_monitor_pkg.sv ----
package event_monitor_pkg;

	localparam int LANES      = 7;
	localparam int LANE_CNT_W = 32;
	localparam int PIX_W      = 16;
	localparam int FIFO_DEPTH = 32;
	localparam int CNT16_W    = 16;
	localparam int NUM_EV     = 24;

	// link error source codes
	localparam logic [2:0] ERR_SRC_NONE   = 3'h0;
	localparam logic [2:0] ERR_SRC_CRC    = 3'h1;
	localparam logic [2:0] ERR_SRC_CODE   = 3'h2;
	localparam logic [2:0] ERR_SRC_PKTOVF = 3'h3;
	localparam logic [2:0] ERR_SRC_RESEND = 3'h4;

	// status vector bits
	localparam int EV_TRIG_USED    = 0;
	localparam int EV_TRIG_IGNORED = 1;
	localparam int EV_ACQ_SOF      = 2;
	localparam int EV_ACQ_EOF      = 3;
	localparam int EV_FRAME_VALID  = 4;
	localparam int EV_LINK_LOCK    = 5;
	localparam int EV_LINK_UNLOCK  = 6;
	localparam int EV_DATA_OVF     = 7;
	localparam int EV_FRAME_LOST   = 8;
	localparam int EV_LTRIG_FAST   = 9;
	localparam int EV_TRIG_SLOW    = 10;
	localparam int EV_REV_OVF      = 11;
	localparam int EV_CAM_MISSED   = 12;
	localparam int EV_CAM_OVERRUN  = 13;
	localparam int EV_LINK_ERROR   = 14;
	localparam int EV_XFER_SOF     = 15;
	localparam int EV_XFER_EOF     = 16;
	localparam int EV_XFER_EOL     = 17;
	localparam int EV_XFER_EONL    = 18;
	localparam int EV_XFER_END     = 19;

	localparam logic [CNT16_W-1:0] CNT16_ZERO = 16'h0000;
	localparam logic [CNT16_W-1:0] CNT16_ONE  = 16'h0001;
	localparam logic [CNT16_W-1:0] CNT16_MAX  = 16'hFFFF;
	localparam logic [LANE_CNT_W-1:0] LANE_CNT_ONE = 32'h0000_0001;

	typedef struct packed {
		logic             sof;
		logic             eol;
		logic             eof;
		logic [PIX_W-1:0] pix;
	} pix_beat_type;

	typedef struct packed {
		logic             err;
		logic [2:0]       src;
		logic [LANES-1:0] lanes;
	} lane_err_type;

	typedef enum logic [1:0] {
		XF_IDLE = 2'b00,
		XF_RUN  = 2'b01,
		XF_STOP = 2'b11
	} xfer_state_type;

endpackage : event_monitor_pkg

// ---- event_fifo.sv ----
`timescale 1ns/1ps
module event_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 32
) (
	input  wire logic             mclk_in,
	input  wire logic             nrst_in,
	input  wire logic             clr_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0]      cnt_r, cnt_nxt;
	logic             wr, rd;

	assign in_ready_out  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid_out = (cnt_r != '0);
	assign out_data_out  = mem[rp_r];
	assign wr = in_valid_in && in_ready_out;
	assign rd = out_valid_out && out_ready_in;

	always_comb begin
		wp_nxt  = wr ? wp_r + 1'b1 : wp_r;
		rp_nxt  = rd ? rp_r + 1'b1 : rp_r;
		cnt_nxt = cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
		if (clr_in) begin
			wp_nxt  = '0;
			rp_nxt  = '0;
			cnt_nxt = '0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// storage has no reset; contents are qualified by the count
	always_ff @(posedge mclk_in) begin
		if (wr && !clr_in) begin
			mem[wp_r] <= in_data_in;
		end
	end
endmodule : event_fifo

// ---- event_monitor_checker.sv ----
`timescale 1ns/1ps
module event_monitor_checker
	import event_monitor_pkg::*;
(
	input wire logic                        mclk_in,
	input wire logic                        nrst_in,
	input wire logic                        cam_fval_in,
	input wire logic                        cam_missed_in,
	input wire logic [LANES-1:0]            lane_lock_in,
	input wire logic [LANES-1:0]            lane_req_in,
	input wire lane_err_type                lane_err_in,
	input wire logic [2:0]                  err_src_out,
	input wire logic [LANES-1:0]            err_lanes_out,
	input wire logic [LANES*LANE_CNT_W-1:0] lane_cnt_out,
	input wire logic                        host_ready_in,
	input wire logic                        host_valid_out,
	input wire pix_beat_type                host_data_out,
	input wire logic [NUM_EV-1:0]           ev_clear_in,
	input wire logic [NUM_EV-1:0]           ev_enable_in,
	input wire logic [NUM_EV-1:0]           ev_status_out,
	input wire logic                        attention_out
);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!nrst_in);

	logic              locked;
	logic              took;
	logic [NUM_EV-1:0] kept;
	assign locked = ((lane_lock_in & lane_req_in) == lane_req_in);
	assign took = host_valid_out && host_ready_in;
	assign kept = ev_status_out & ~ev_clear_in;

	a_lock_event: assert property (
		$rose(locked) |=> ev_status_out[EV_LINK_LOCK])
		else $error("lock event missing");
	a_unlock_event: assert property (
		$fell(locked) |=> ev_status_out[EV_LINK_UNLOCK])
		else $error("unlock event missing");
	a_err_report: assert property (lane_err_in.err |=>
		err_src_out == $past(lane_err_in.src)
		&& err_lanes_out == $past(lane_err_in.lanes)
		&& ev_status_out[EV_LINK_ERROR])
		else $error("error report wrong");
	a_lane_count: assert property (
		lane_err_in.err && lane_err_in.lanes[0] |=>
		lane_cnt_out[31:0] == $past(lane_cnt_out[31:0]) + LANE_CNT_ONE)
		else $error("lane count stuck");
	a_count_hold: assert property (
		!lane_err_in.err |=> $stable(lane_cnt_out))
		else $error("lane count moved");
	a_cam_missed: assert property (
		cam_missed_in |=> ev_status_out[EV_CAM_MISSED])
		else $error("missed event missing");
	a_frame_valid: assert property (
		$rose(cam_fval_in) |-> ##[1:2] ev_status_out[EV_FRAME_VALID])
		else $error("frame valid missing");
	a_xfer_sof: assert property (
		took && host_data_out.sof |=> ev_status_out[EV_XFER_SOF])
		else $error("xfer sof missing");
	a_xfer_eof: assert property (
		took && host_data_out.eof |=> ev_status_out[EV_XFER_EOF])
		else $error("xfer eof missing");
	a_sticky_flags: assert property (
		nrst_in |=> (ev_status_out & $past(kept)) == $past(kept))
		else $error("status flag dropped");
	a_attention_or: assert property (
		attention_out == |(ev_status_out & ev_enable_in))
		else $error("attention wrong");

	c_lock: cover property ($rose(locked));
	c_lost: cover property ($rose(ev_status_out[EV_FRAME_LOST]));
	c_eof: cover property (took && host_data_out.eof);
endmodule : event_monitor_checker

bind acquisition_event_monitor event_monitor_checker chk_i (.*);

// ---- camera_model.sv ----
`timescale 1ns/1ps
module camera_model
	import event_monitor_pkg::*;
(
	input  wire logic    mclk_in,
	output logic         fval_out,
	output logic         lval_out,
	output logic         valid_out,
	output pix_beat_type beat_out
);
	initial begin
		{fval_out, lval_out, valid_out, beat_out} = '0;
	end

	task automatic step();
		@(posedge mclk_in);
		#1;
	endtask : step

	// gap: idle cycles before each line
	task automatic send(input int lines, input int pixels,
			input logic [15:0] base, input int gap);
		int n = 0;
		fval_out = 1'b1;
		for (int l = 0; l < lines; l++) begin
			repeat (gap) step();
			lval_out = 1'b1;
			valid_out = 1'b1;
			for (int p = 0; p < pixels; p++) begin
				beat_out.sof = (l == 0) && (p == 0);
				beat_out.eol = (p == pixels - 1);
				beat_out.eof = beat_out.eol && (l == lines - 1);
				beat_out.pix = base + 16'(n);
				n++;
				step();
			end
			lval_out = 1'b0;
			valid_out = 1'b0;
			// idle data must not pass for a repeat of the last pixel
			beat_out.pix = ~beat_out.pix;
		end
		repeat (gap) step();
		fval_out = 1'b0;
	endtask : send
endmodule : camera_model

// ---- acquisition_event_monitor_bench.sv ----
`timescale 1ns/1ps
module acquisition_event_monitor_bench
	import event_monitor_pkg::*;
;
	logic mclk_in = 1'b0;
	logic nrst_in, ext_trig_in, acq_active_in, cam_ready_in;
	logic cam_fval_in, cam_lval_in, line_trig_in, line_trig_out;
	logic enc_pulse_in, enc_reverse_in, cam_missed_in, cam_overrun_in;
	logic pix_valid_in, store_busy_in, xfer_start_in, xfer_stop_in;
	logic host_ready_in, host_valid_out, xfer_busy_out, attention_out;
	logic [CNT16_W-1:0] debounce_cycles_in, enc_min_period_in;
	logic [CNT16_W-1:0] enc_rev_limit_in, xfer_frames_in, nlines_in;
	logic [LANES-1:0] lane_lock_in, lane_req_in, err_lanes_out;
	logic [2:0] err_src_out;
	logic [LANES*LANE_CNT_W-1:0] lane_cnt_out;
	logic [NUM_EV-1:0] ev_clear_in, ev_enable_in, ev_status_out;
	lane_err_type lane_err_in;
	pix_beat_type pix_in, host_data_out;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;

	acquisition_event_monitor uut (.*);

	camera_model cam (
		.mclk_in   (mclk_in),
		.fval_out  (cam_fval_in),
		.lval_out  (cam_lval_in),
		.valid_out (pix_valid_in),
		.beat_out  (pix_in)
	);

	always #12.5 mclk_in = ~mclk_in;

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test

	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			end_of_test();
		end
	end

	task automatic tick(input int n);
		repeat (n) begin
			@(posedge mclk_in);
			#1;
		end
	endtask : tick

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic ev(input int i, input logic v);
		chk(32'(ev_status_out[i]), 32'(v));
	endtask : ev

	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
		tick(1);
	endtask : pulse

	task automatic clr();
		ev_clear_in = '1;
		tick(1);
		ev_clear_in = '0;
	endtask : clr

	task automatic trig(input int n);
		ext_trig_in = 1'b1;
		tick(n);
		ext_trig_in = 1'b0;
		tick(2);
	endtask : trig

	task automatic enc(input int period);
		enc_pulse_in = 1'b1;
		tick(1);
		enc_pulse_in = 1'b0;
		tick(period - 1);
	endtask : enc

	task automatic idle();
		for (int i = 0; i < 50 && xfer_busy_out !== 1'b0; i++) tick(1);
	endtask : idle

	task automatic outs(output int n);
		n = 0;
		for (int i = 0; i < 4; i++) begin
			n += (line_trig_out === 1'b1);
			tick(1);
		end
	endtask : outs

	task automatic t_trigger();
		acq_active_in = 1'b1;
		clr();
		trig(2);
		ev(EV_TRIG_USED, 1'b0);
		ev(EV_TRIG_IGNORED, 1'b0);
		trig(7);
		ev(EV_TRIG_USED, 1'b0);
		ev(EV_TRIG_IGNORED, 1'b1);
		cam_ready_in = 1'b1;
		trig(7);
		ev(EV_TRIG_USED, 1'b1);
		cam.send(2, 8, 16'h0100, 1);
		tick(3);
		ev(EV_ACQ_SOF, 1'b1);
		ev(EV_ACQ_EOF, 1'b1);
		ev(EV_FRAME_VALID, 1'b1);
		$display("trigger done");
	endtask : t_trigger

	task automatic t_lost();
		clr();
		cam.send(2, 8, 16'h0200, 0);
		tick(2);
		ev(EV_FRAME_LOST, 1'b0);
		ev(EV_DATA_OVF, 1'b0);
		cam.send(2, 8, 16'h0300, 0);
		tick(2);
		ev(EV_FRAME_LOST, 1'b1);
		$display("lost done");
	endtask : t_lost

	task automatic t_drain();
		int k = 0;
		clr();
		pulse(xfer_start_in);
		for (int c = 0; c < 300 && k < 32; c++) begin
			host_ready_in = c[1];
			#2;
			if (host_ready_in && host_valid_out) begin
				chk(host_data_out.pix, k < 16 ? 32'h100 + k : 32'h1F0 + k);
				chk(host_data_out.sof, k % 16 == 0);
				chk(host_data_out.eof, k % 16 == 15);
				chk(host_data_out.eol, k % 8 == 7);
				k++;
			end
			tick(1);
		end
		host_ready_in = 1'b0;
		idle();
		tick(2);
		chk(32'(k), 32'h20);
		chk(host_valid_out, 1'b0);
		chk(xfer_busy_out, 1'b0);
		ev(EV_XFER_SOF, 1'b1);
		ev(EV_XFER_EOF, 1'b1);
		ev(EV_XFER_EOL, 1'b1);
		ev(EV_XFER_EONL, 1'b1);
		ev(EV_XFER_END, 1'b1);
		$display("drain done");
	endtask : t_drain

	task automatic t_stop();
		xfer_frames_in = 16'h0000;
		nlines_in = 16'h0001;
		host_ready_in = 1'b1;
		clr();
		pulse(xfer_start_in);
		cam.send(2, 8, 16'h0400, 3);
		tick(8);
		chk(xfer_busy_out, 1'b1);
		ev(EV_XFER_EOF, 1'b1);
		ev(EV_XFER_EONL, 1'b1);
		ev(EV_XFER_END, 1'b0);
		pulse(xfer_stop_in);
		idle();
		tick(2);
		chk(xfer_busy_out, 1'b0);
		ev(EV_XFER_END, 1'b1);
		$display("stop done");
	endtask : t_stop

	task automatic t_link();
		logic [6:0] masks [4] = '{7'h01, 7'h03, 7'h05, 7'h41};
		lane_req_in = 7'h0F;
		clr();
		lane_lock_in = 7'h0F;
		tick(2);
		ev(EV_LINK_LOCK, 1'b1);
		lane_lock_in = 7'h07;
		tick(2);
		ev(EV_LINK_UNLOCK, 1'b1);
		for (int i = 0; i < 4; i++) begin
			clr();
			lane_err_in = '{1'b1, 3'(i + 1), masks[i]};
			tick(1);
			lane_err_in = '0;
			tick(1);
			chk(err_src_out, 32'(i + 1));
			chk(err_lanes_out, masks[i]);
			ev(EV_LINK_ERROR, 1'b1);
		end
		chk(lane_cnt_out[31:0], 32'h4);
		chk(lane_cnt_out[63:32], 32'h1);
		chk(lane_cnt_out[95:64], 32'h1);
		chk(lane_cnt_out[127:96], 32'h0);
		chk(lane_cnt_out[223:192], 32'h1);
		$display("link done");
	endtask : t_link

	task automatic t_cam();
		clr();
		ev_enable_in[EV_CAM_MISSED] = 1'b1;
		pulse(cam_overrun_in);
		ev(EV_CAM_OVERRUN, 1'b1);
		chk(attention_out, 1'b0);
		pulse(cam_missed_in);
		ev(EV_CAM_MISSED, 1'b1);
		chk(attention_out, 1'b1);
		ev_clear_in[EV_CAM_MISSED] = 1'b1;
		tick(1);
		ev_clear_in = '0;
		tick(1);
		ev(EV_CAM_MISSED, 1'b0);
		ev(EV_CAM_OVERRUN, 1'b1);
		chk(attention_out, 1'b0);
		$display("camera done");
	endtask : t_cam

	task automatic t_enc();
		repeat (3) enc(4);
		clr();
		repeat (2) enc(4);
		ev(EV_TRIG_SLOW, 1'b0);
		repeat (3) enc(14);
		ev(EV_TRIG_SLOW, 1'b1);
		enc_reverse_in = 1'b1;
		repeat (3) enc(4);
		ev(EV_REV_OVF, 1'b0);
		enc(4);
		ev(EV_REV_OVF, 1'b1);
		enc_reverse_in = 1'b0;
		$display("encoder done");
	endtask : t_enc

	task automatic t_line();
		int n;
		clr();
		line_trig_in = 1'b1;
		tick(1);
		line_trig_in = 1'b0;
		outs(n);
		chk(32'(n), 32'h1);
		line_trig_in = 1'b1;
		tick(1);
		line_trig_in = 1'b0;
		outs(n);
		chk(32'(n), 32'h0);
		ev(EV_LTRIG_FAST, 1'b1);
		cam.send(1, 4, 16'h0500, 0);
		outs(n);
		chk(32'(n), 32'h1);
		$display("line done");
	endtask : t_line

	task automatic t_idle();
		acq_active_in = 1'b0;
		clr();
		store_busy_in = 1'b1;
		cam.send(1, 4, 16'h0600, 1);
		store_busy_in = 1'b0;
		tick(3);
		ev(EV_FRAME_VALID, 1'b1);
		ev(EV_ACQ_SOF, 1'b0);
		ev(EV_DATA_OVF, 1'b1);
		$display("idle done");
	endtask : t_idle

	initial begin
		{nrst_in, ext_trig_in, acq_active_in, cam_ready_in} = '0;
		{enc_pulse_in, enc_reverse_in, cam_missed_in, cam_overrun_in} = '0;
		{store_busy_in, xfer_start_in, xfer_stop_in, host_ready_in} = '0;
		{line_trig_in, ev_clear_in, ev_enable_in} = '0;
		{lane_lock_in, lane_err_in} = '0;
		debounce_cycles_in = 16'h0004;
		enc_min_period_in = 16'h0008;
		enc_rev_limit_in = 16'h0003;
		xfer_frames_in = 16'h0002;
		nlines_in = 16'h0002;
		lane_req_in = 7'h7F;
		tick(12);
		nrst_in = 1'b1;
		tick(1);
		chk(ev_status_out, '0);
		chk(lane_cnt_out[31:0], '0);
		chk(xfer_busy_out, 1'b0);
		$display("reset done");
		t_trigger();
		t_lost();
		t_drain();
		t_stop();
		t_link();
		t_cam();
		t_enc();
		t_line();
		t_idle();
		end_of_test();
	end
endmodule : acquisition_event_monitor_bench
